// ---- rtl/gdr_pkg.sv ----
/*
 * Constants, codes and carrier types for the gas detector holding-register bank.
 * Assumes a serial front end that has already turned each frame into one
 * single-register access.
 */
package gdr_pkg;

   // ***************************************************************
   // Register addresses (16-bit holding-register index)
   // ***************************************************************
   localparam logic [15:0] GDR_A_GAS = 16'h0001;
   localparam logic [15:0] GDR_A_NODE = 16'h0003;
   localparam logic [15:0] GDR_A_KIND = 16'h0004;
   localparam logic [15:0] GDR_A_UNIT = 16'h0005;
   localparam logic [15:0] GDR_A_FW_MAJ = 16'h0006;
   localparam logic [15:0] GDR_A_FW_MIN = 16'h0007;
   localparam logic [15:0] GDR_A_MODE = 16'h0008;
   localparam logic [15:0] GDR_A_VOLT = 16'h0009;
   localparam logic [15:0] GDR_A_FAULT = 16'h000B;
   localparam logic [15:0] GDR_A_TECH = 16'h000C;
   localparam logic [15:0] GDR_A_THR1 = 16'h000E;
   localparam logic [15:0] GDR_A_THR2 = 16'h0010;
   localparam logic [15:0] GDR_A_PREC = 16'h0016;
   localparam logic [15:0] GDR_A_RCFG = 16'h0017;
   localparam logic [15:0] GDR_A_ZAGE = 16'h0018;
   localparam logic [15:0] GDR_A_CMETH = 16'h0019;
   localparam logic [15:0] GDR_A_ACAL = 16'h001A;
   localparam logic [15:0] GDR_A_CAGE = 16'h001C;
   localparam logic [15:0] GDR_A_R1STAT = 16'h001E;
   localparam logic [15:0] GDR_A_R2STAT = 16'h001F;
   localparam logic [15:0] GDR_A_R1CLR = 16'h0020;
   localparam logic [15:0] GDR_A_R2CLR = 16'h0021;

   // ***************************************************************
   // Field positions of the relay configuration bit field
   // ***************************************************************
   localparam int GDR_RCFG_LATCH_LSB = 0;
   localparam int GDR_RCFG_FSAFE_LSB = 2;
   localparam int GDR_RCFG_RISE_LSB = 4;
   localparam int GDR_RCFG_W = 6;

   // ***************************************************************
   // Values and codes
   // ***************************************************************
   localparam logic [15:0] GDR_DAYS_MAX = 16'hEA60;
   localparam logic [15:0] GDR_DAYS_NEVER = 16'hFFFF;
   localparam logic [15:0] GDR_CLR_CMD = 16'h0001;
   localparam logic [15:0] GDR_ZERO16 = 16'h0000;
   localparam logic [7:0] GDR_EXC_NONE = 8'h00;
   localparam logic [7:0] GDR_EXC_ADDR = 8'h02;
   localparam logic [15:0] GDR_KIND_VOLATILE_ORGANIC_GAS = 16'h0007;
   localparam logic [15:0] GDR_UNIT_PPM = 16'h0000;
   localparam logic [15:0] GDR_UNIT_PCT = 16'h0001;
   localparam logic [15:0] GDR_TECH_PHOTOIONIZATION_SENSOR = 16'h0004;
   localparam logic [1:0] GDR_RST_SYNC_INIT = 2'h0;

   typedef enum logic [2:0] {
      GDR_MODE_NORMAL = 3'h0,
      GDR_MODE_ZEROING = 3'h1,
      GDR_MODE_CAL = 3'h2,
      GDR_MODE_ALARM_TEST = 3'h3,
      GDR_MODE_DIAG = 3'h5,
      GDR_MODE_ADVANCED = 3'h6,
      GDR_MODE_ADMIN = 3'h7
   } gdr_mode_e;

   typedef enum logic [2:0] {
      GDR_FLT_NONE = 3'h0,
      GDR_FLT_BOARD_LINK = 3'h1,
      GDR_FLT_ELEMENT_LINK = 3'h4,
      GDR_FLT_ZERO_ERR = 3'h5,
      GDR_FLT_CAL_ERR = 3'h6
   } gdr_fault_e;

   typedef enum logic [2:0] {
      GDR_TECH_ECHEM = 3'h0,
      GDR_TECH_INFRARED = 3'h1,
      GDR_TECH_CAT_BEAD = 3'h2,
      GDR_TECH_PHOTOION = 3'h4
   } gdr_tech_e;

   // ***************************************************************
   // Carriers
   // ***************************************************************
   typedef struct packed {
      logic valid;
      logic write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } gdr_req_s;

   typedef struct packed {
      logic valid;
      logic [7:0] exc;
      logic [15:0] rdata;
   } gdr_rsp_s;

   typedef struct packed {
      logic [31:0] gas;
      logic [31:0] volt;
      logic [31:0] thr1;
      logic [31:0] thr2;
      logic [31:0] acal;
      logic [15:0] node;
      logic unit_pct;
      gdr_mode_e mode;
      gdr_fault_e fault;
      gdr_tech_e tech;
      logic [15:0] precision;
      logic [GDR_RCFG_W-1:0] rcfg;
      logic [15:0] zero_days;
      logic [15:0] cal_days;
      logic cal_auto;
   } gdr_stat_s;

endpackage

// ---- rtl/gdr_regbank.sv ----
/*
 * Holding-register bank of the gas detector, with the relay latch logic
 * that its two clear registers act on.
 * Assumes a serial front end that hands over one decoded register access
 * per request pulse and accepts a one-cycle answer pulse in return; all
 * live values arrive synchronous to i_clk_sys.
 */
//
// Function
// - Bank is reached by serial-bus register accesses shared by many nodes.
// - Each float value spans two consecutive 16-bit registers from its address.
// - Only the two relay-clear registers take writes; all others are read-only.
// - Writing 1 to clear register one drops relay one latch; reads give 0.
// - Writing 1 to clear register two drops relay two latch; reads give 0.
// - Day counters read 0 to 60000; anything higher means never done.
// - Gas kind register holds an enumerated code, 7 for organic vapours.
// - Unit register reads 0 for ppm and 1 for percent.
// - Mode codes 0,1,2,3,5,6,7 as listed; code 4 unused.
// - Fault codes 0,1,4,5,6 as listed.
// - Technology codes 0,1,2 and 4 as listed.
// - Config bits 0 and 1 pick latch or auto reset per relay.
// - Config bits 2 and 3 enable failsafe per relay.
// - Config bits 4 and 5 pick rising or falling alarm direction.
// - Calibration method reads 0 manual, 1 automatic.
`timescale 1ns/1ns
module gdr_regbank
   import gdr_pkg::*;
#(
   parameter logic [15:0] FW_MAJOR = 16'h0001, // Arbitrary value
   parameter logic [15:0] FW_MINOR = 16'h0000, // Arbitrary value
   parameter logic [15:0] GAS_KIND = GDR_KIND_VOLATILE_ORGANIC_GAS,
   parameter int N_RELAY = 2
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // Register access from the serial front end
   input wire gdr_req_s i_req,
   output gdr_rsp_s o_rsp,
   // Live detector values
   input wire gdr_stat_s i_stat,
   // Alarm conditions from the measurement path, level per relay
   input wire logic [N_RELAY-1:0] i_gas_above,
   // Relay outputs
   output logic [N_RELAY-1:0] o_relay_active,
   output logic [N_RELAY-1:0] o_relay_coil
);

   // ***************************************************************
   // Reset release
   // ***************************************************************
   logic [1:0] rst_sync_ff;
   logic rstn;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_sync_ff <= GDR_RST_SYNC_INIT;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rstn = rst_sync_ff[1];

   // ***************************************************************
   // Address decode
   // ***************************************************************
   logic [15:0] a;
   logic hit_ro;
   logic hit_clr1;
   logic hit_clr2;
   logic [15:0] rd_val;
   logic [N_RELAY-1:0] clr_req;

   // Day counters: anything past the limit reads as the never code
   function automatic logic [15:0] days_rd(input logic [15:0] d);
      return (d > GDR_DAYS_MAX) ? GDR_DAYS_NEVER : d;
   endfunction

   assign a = i_req.addr;

   always_comb begin
      hit_ro = 1'b1;
      hit_clr1 = 1'b0;
      hit_clr2 = 1'b0;
      rd_val = GDR_ZERO16;
      // Floats: high word at the listed address, low word one above
      if (a == GDR_A_GAS) begin
         rd_val = i_stat.gas[31:16];
      end else if (a == GDR_A_GAS + 16'h0001) begin
         rd_val = i_stat.gas[15:0];
      end else if (a == GDR_A_NODE) begin
         rd_val = i_stat.node;
      end else if (a == GDR_A_KIND) begin
         rd_val = GAS_KIND;
      end else if (a == GDR_A_UNIT) begin
         rd_val = i_stat.unit_pct ? GDR_UNIT_PCT : GDR_UNIT_PPM;
      end else if (a == GDR_A_FW_MAJ) begin
         rd_val = FW_MAJOR;
      end else if (a == GDR_A_FW_MIN) begin
         rd_val = FW_MINOR;
      end else if (a == GDR_A_MODE) begin
         rd_val = {13'h0000, i_stat.mode};
      end else if (a == GDR_A_VOLT) begin
         rd_val = i_stat.volt[31:16];
      end else if (a == GDR_A_VOLT + 16'h0001) begin
         rd_val = i_stat.volt[15:0];
      end else if (a == GDR_A_FAULT) begin
         rd_val = {13'h0000, i_stat.fault};
      end else if (a == GDR_A_TECH) begin
         rd_val = {13'h0000, i_stat.tech};
      end else if (a == GDR_A_THR1) begin
         rd_val = i_stat.thr1[31:16];
      end else if (a == GDR_A_THR1 + 16'h0001) begin
         rd_val = i_stat.thr1[15:0];
      end else if (a == GDR_A_THR2) begin
         rd_val = i_stat.thr2[31:16];
      end else if (a == GDR_A_THR2 + 16'h0001) begin
         rd_val = i_stat.thr2[15:0];
      end else if (a == GDR_A_PREC) begin
         rd_val = i_stat.precision;
      end else if (a == GDR_A_RCFG) begin
         rd_val = {10'h000, i_stat.rcfg};
      end else if (a == GDR_A_ZAGE) begin
         rd_val = days_rd(i_stat.zero_days);
      end else if (a == GDR_A_CMETH) begin
         rd_val = {15'h0000, i_stat.cal_auto};
      end else if (a == GDR_A_ACAL) begin
         rd_val = i_stat.acal[31:16];
      end else if (a == GDR_A_ACAL + 16'h0001) begin
         rd_val = i_stat.acal[15:0];
      end else if (a == GDR_A_CAGE) begin
         rd_val = days_rd(i_stat.cal_days);
      end else if (a == GDR_A_R1STAT) begin
         rd_val = {15'h0000, o_relay_active[0]};
      end else if (a == GDR_A_R2STAT) begin
         rd_val = {15'h0000, o_relay_active[1]};
      end else if (a == GDR_A_R1CLR) begin
         hit_ro = 1'b0;
         hit_clr1 = 1'b1;
         rd_val = GDR_ZERO16;
      end else if (a == GDR_A_R2CLR) begin
         hit_ro = 1'b0;
         hit_clr2 = 1'b1;
         rd_val = GDR_ZERO16;
      end else begin
         hit_ro = 1'b0;
      end
   end

   // Only a value of exactly 1 clears; other values are taken and ignored
   assign clr_req[0] = i_req.valid && i_req.write && hit_clr1 &&
                       (i_req.wdata == GDR_CLR_CMD);
   assign clr_req[1] = i_req.valid && i_req.write && hit_clr2 &&
                       (i_req.wdata == GDR_CLR_CMD);

   // ***************************************************************
   // Answer to the front end
   // ***************************************************************
   logic bad;
   gdr_rsp_s rsp_ff;

   // Writes to read-only and all unmapped accesses are refused
   assign bad = i_req.write ? !(hit_clr1 || hit_clr2) :
                !(hit_ro || hit_clr1 || hit_clr2);

   always_ff @(posedge i_clk_sys or negedge rstn) begin
      if (!rstn) begin
         rsp_ff <= '0;
      end else begin
         rsp_ff.valid <= i_req.valid;
         rsp_ff.exc <= (i_req.valid && bad) ? GDR_EXC_ADDR : GDR_EXC_NONE;
         rsp_ff.rdata <= (i_req.valid && !bad && !i_req.write) ? rd_val : GDR_ZERO16;
      end
   end
   assign o_rsp = rsp_ff;

   // ***************************************************************
   // Relay state, one slice per relay
   // ***************************************************************
   logic [N_RELAY-1:0] active_ff;
   logic [N_RELAY-1:0] coil_ff;

   genvar g;
   generate
      for (g = 0; g < N_RELAY; g++) begin : g_relay
         logic latch_en;
         logic fsafe;
         logic rising;
         logic trip;
         logic nxt_active;

         assign latch_en = i_stat.rcfg[GDR_RCFG_LATCH_LSB + g];
         assign fsafe = i_stat.rcfg[GDR_RCFG_FSAFE_LSB + g];
         assign rising = i_stat.rcfg[GDR_RCFG_RISE_LSB + g];
         // Falling alarms trip when the reading sits below the threshold
         assign trip = rising ? i_gas_above[g] : !i_gas_above[g];

         // A trip in the clearing cycle keeps the relay set
         always_comb begin
            if (trip) begin
               nxt_active = 1'b1;
            end else if (latch_en) begin
               nxt_active = active_ff[g] && !clr_req[g];
            end else begin
               nxt_active = 1'b0;
            end
         end

         always_ff @(posedge i_clk_sys or negedge rstn) begin
            if (!rstn) begin
               active_ff[g] <= 1'b0;
               coil_ff[g] <= 1'b0;
            end else begin
               active_ff[g] <= nxt_active;
               // Failsafe coil is held energised and drops on alarm
               coil_ff[g] <= fsafe ? !nxt_active : nxt_active;
            end
         end
      end
   endgenerate

   assign o_relay_active = active_ff;
   assign o_relay_coil = coil_ff;

endmodule

// ---- tb/gdr_checker.sv ----
/* Port assertions for the gas detector register bank.
 * Bound onto gdr_regbank and sees only its ports. */
`timescale 1ns/1ns
module gdr_checker
   import gdr_pkg::*;
#(
   parameter int N_RELAY = 2
) (
   // Clock, reset, register port
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire gdr_req_s i_req,
   input wire gdr_rsp_s o_rsp,
   // Live values and relays
   input wire gdr_stat_s i_stat,
   input wire logic [N_RELAY-1:0] i_gas_above,
   input wire logic [N_RELAY-1:0] o_relay_active,
   input wire logic [N_RELAY-1:0] o_relay_coil
);
   // Relay checks wait out the two-flop reset release
   logic [1:0] up_ff;
   logic rdy;
   logic trip0;
   logic clr0;
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         up_ff <= 2'h0;
      end else if (!rdy) begin
         up_ff <= up_ff + 2'h1;
      end
   end
   assign rdy = up_ff == 2'h3;
   assign trip0 = i_stat.rcfg[GDR_RCFG_RISE_LSB] ? i_gas_above[0] : !i_gas_above[0];
   assign clr0 = i_req.valid && i_req.write && i_req.addr == GDR_A_R1CLR
      && i_req.wdata == GDR_CLR_CMD;
   default clocking cb_sys @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   // *****
   // Properties
   // *****
   sequence s_rd(logic [15:0] a); i_req.valid && !i_req.write && i_req.addr == a; endsequence
   sequence s_zero; o_rsp.valid && o_rsp.exc == GDR_EXC_NONE && o_rsp.rdata == GDR_ZERO16;
   endsequence
   property p_answer; i_req.valid |=> o_rsp.valid; endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_ro_write; i_req.valid && i_req.write && i_req.addr != GDR_A_R1CLR
      && i_req.addr != GDR_A_R2CLR |=> o_rsp.exc == GDR_EXC_ADDR; endproperty
   a_ro_write: assert property (p_ro_write) else $error("write not refused");
   property p_clr_read; s_rd(GDR_A_R1CLR) |=> s_zero; endproperty
   a_clr_read: assert property (p_clr_read) else $error("clear reg not zero");
   property p_days; s_rd(GDR_A_ZAGE) |=> o_rsp.rdata == (($past(i_stat.zero_days) >
      GDR_DAYS_MAX) ? GDR_DAYS_NEVER : $past(i_stat.zero_days)); endproperty
   a_days: assert property (p_days) else $error("day count wrong");
   property p_auto; rdy && !i_stat.rcfg[0] |=> o_relay_active[0] == $past(trip0); endproperty
   a_auto: assert property (p_auto) else $error("auto relay wrong");
   property p_hold; rdy && i_stat.rcfg[0] && o_relay_active[0] && !clr0 |=> o_relay_active[0];
   endproperty
   a_hold: assert property (p_hold) else $error("latch lost");
   property p_clear; rdy && i_stat.rcfg[0] && clr0 && !trip0 |=> !o_relay_active[0]; endproperty
   a_clear: assert property (p_clear) else $error("clear ignored");
   property p_coil; rdy |-> o_relay_coil[0] ==
      (o_relay_active[0] ^ $past(i_stat.rcfg[GDR_RCFG_FSAFE_LSB])); endproperty
   a_coil: assert property (p_coil) else $error("coil drive wrong");
endmodule
bind gdr_regbank gdr_checker #(.N_RELAY(N_RELAY)) u_chk (.i_clk_sys(i_clk_sys),
   .i_rstn(i_rstn), .i_req(i_req), .o_rsp(o_rsp), .i_stat(i_stat), .i_gas_above(i_gas_above),
   .o_relay_active(o_relay_active), .o_relay_coil(o_relay_coil));

// ---- tb/gdr_master_model.sv ----
/* Bus master model: one single-register access at a time.
 * Assumes the bank answers in the cycle after the taking edge. */
`timescale 1ns/1ns
module gdr_master_model
   import gdr_pkg::*;
(
   // Clock
   input wire logic i_clk_sys,
   // Register port
   output gdr_req_s o_req,
   input wire gdr_rsp_s i_rsp
);
   initial o_req = '0;
   task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
         output gdr_rsp_s r);
      @(negedge i_clk_sys);
      o_req = '{1'b1, w, a, d};
      @(negedge i_clk_sys);
      r = i_rsp;
      // Released fields flip so a stale value never passes for a fresh one
      o_req = '{1'b0, !w, ~a, ~d};
   endtask
endmodule

// ---- tb/tb.sv ----
/* Self-checking bench for the gas detector register bank.
 * Assumes the package in rtl/ and the master model beside this file. */
`timescale 1ns/1ns
module tb
   import gdr_pkg::*;
;
   logic i_clk_sys;
   logic i_rstn;
   gdr_req_s req;
   gdr_rsp_s rsp;
   gdr_stat_s st;
   logic [1:0] above;
   logic [1:0] act;
   logic [1:0] coil;
   int fail_count;
   int samples_checked;
   // Firmware revision values are arbitrary
   gdr_regbank #(.FW_MAJOR(16'h0003), .FW_MINOR(16'h0002)) dut (.i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn), .i_req(req), .o_rsp(rsp), .i_stat(st), .i_gas_above(above),
      .o_relay_active(act), .o_relay_coil(coil));
   gdr_master_model master (.i_clk_sys(i_clk_sys), .o_req(req), .i_rsp(rsp));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_exc(input string n, input logic [7:0] e, input logic [7:0] g);
      chk(n, {8'h00, e}, {8'h00, g});
   endtask
   task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
         input logic [7:0] ex, input logic [15:0] e);
      gdr_rsp_s r;
      master.xfer(w, a, d, r);
      chk_exc($sformatf("valid %h", a), 8'h01, {7'h00, r.valid});
      chk_exc($sformatf("exc %h", a), ex, r.exc);
      if (!w || ex != GDR_EXC_NONE) chk($sformatf("word %h", a), e, r.rdata);
   endtask
   task automatic relays(input logic [1:0] ea, input logic [1:0] ec);
      @(negedge i_clk_sys);
      chk("active", {14'h0000, ea}, {14'h0000, act});
      chk("coil", {14'h0000, ec}, {14'h0000, coil});
   endtask
   function automatic logic [15:0] days(input logic [15:0] v);
      return (v > GDR_DAYS_MAX) ? GDR_DAYS_NEVER : v;
   endfunction
   // Sweeps run with both relays idle, so status words read zero
   function automatic void model(input logic [15:0] a, output logic ok, output logic [15:0] e);
      ok = 1'b1;
      e = GDR_ZERO16;
      case (a)
         GDR_A_GAS: e = st.gas[31:16];
         GDR_A_GAS + 16'h0001: e = st.gas[15:0];
         GDR_A_NODE: e = st.node;
         GDR_A_KIND: e = GDR_KIND_VOLATILE_ORGANIC_GAS;
         GDR_A_UNIT: e = {15'h0000, st.unit_pct};
         GDR_A_FW_MAJ: e = 16'h0003;
         GDR_A_FW_MIN: e = 16'h0002;
         GDR_A_MODE: e = {13'h0000, st.mode};
         GDR_A_VOLT: e = st.volt[31:16];
         GDR_A_VOLT + 16'h0001: e = st.volt[15:0];
         GDR_A_FAULT: e = {13'h0000, st.fault};
         GDR_A_TECH: e = {13'h0000, st.tech};
         GDR_A_THR1: e = st.thr1[31:16];
         GDR_A_THR1 + 16'h0001: e = st.thr1[15:0];
         GDR_A_THR2: e = st.thr2[31:16];
         GDR_A_THR2 + 16'h0001: e = st.thr2[15:0];
         GDR_A_PREC: e = st.precision;
         GDR_A_RCFG: e = {10'h000, st.rcfg};
         GDR_A_ZAGE: e = days(st.zero_days);
         GDR_A_CMETH: e = {15'h0000, st.cal_auto};
         GDR_A_ACAL: e = st.acal[31:16];
         GDR_A_ACAL + 16'h0001: e = st.acal[15:0];
         GDR_A_CAGE: e = days(st.cal_days);
         GDR_A_R1STAT, GDR_A_R2STAT, GDR_A_R1CLR, GDR_A_R2CLR: e = GDR_ZERO16;
         default: ok = 1'b0;
      endcase
   endfunction
   task automatic sweep();
      logic ok;
      logic [15:0] e;
      for (int a = 0; a < 36; a++) begin
         model(16'(a), ok, e);
         acc(1'b0, 16'(a), 16'h0000, ok ? GDR_EXC_NONE : GDR_EXC_ADDR, e);
         ok = 16'(a) == GDR_A_R1CLR || 16'(a) == GDR_A_R2CLR;
         acc(1'b1, 16'(a), GDR_CLR_CMD, ok ? GDR_EXC_NONE : GDR_EXC_ADDR, GDR_ZERO16);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      #100000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      i_rstn = 1'b0;
      above = 2'h3;
      st = '{32'h4148_CCCD, 32'h41C0_0000, 32'h4120_0000, 32'h41A0_0000, 32'h4248_0000,
         16'h002A, 1'b1, GDR_MODE_NORMAL, GDR_FLT_NONE, GDR_TECH_PHOTOION, 16'h0002,
         6'h00, 16'h0005, 16'h0009, 1'b0};
      repeat (10) @(negedge i_clk_sys);
      i_rstn = 1'b1;
      repeat (3) @(negedge i_clk_sys);
      sweep();
      st.zero_days = GDR_DAYS_MAX;
      st.cal_days = GDR_DAYS_MAX + 16'h0001;
      st.unit_pct = 1'b0;
      st.cal_auto = 1'b1;
      st.rcfg = 6'h0F;
      sweep();
      for (int m = 0; m < 8; m++) begin
         st.mode = gdr_mode_e'(m);
         st.fault = gdr_fault_e'(m);
         st.tech = gdr_tech_e'(m);
         if (m != 4) acc(1'b0, GDR_A_MODE, 16'h0000, GDR_EXC_NONE, 16'(m));
         if (m inside {0, 1, 4, 5, 6}) begin
            acc(1'b0, GDR_A_FAULT, 16'h0000, GDR_EXC_NONE, 16'(m));
         end
         if (m inside {0, 1, 2, 4}) acc(1'b0, GDR_A_TECH, 16'h0000, GDR_EXC_NONE, 16'(m));
      end
      $display("register map test done");
      st.rcfg = 6'h15;
      above = 2'h2;
      relays(2'h0, 2'h1);
      above = 2'h3;
      relays(2'h1, 2'h0);
      above = 2'h2;
      relays(2'h1, 2'h0);
      acc(1'b0, GDR_A_R1STAT, 16'h0000, GDR_EXC_NONE, 16'h0001);
      acc(1'b1, GDR_A_R1CLR, 16'h0002, GDR_EXC_NONE, GDR_ZERO16);
      acc(1'b1, GDR_A_R2CLR, GDR_CLR_CMD, GDR_EXC_NONE, GDR_ZERO16);
      relays(2'h1, 2'h0);
      acc(1'b1, GDR_A_R1CLR, GDR_CLR_CMD, GDR_EXC_NONE, GDR_ZERO16);
      relays(2'h0, 2'h1);
      above = 2'h0;
      relays(2'h2, 2'h3);
      acc(1'b0, GDR_A_R2STAT, 16'h0000, GDR_EXC_NONE, 16'h0001);
      above = 2'h2;
      relays(2'h0, 2'h1);
      st.rcfg = 6'h12;
      above = 2'h0;
      relays(2'h2, 2'h2);
      above = 2'h2;
      relays(2'h2, 2'h2);
      acc(1'b1, GDR_A_R2CLR, GDR_CLR_CMD, GDR_EXC_NONE, GDR_ZERO16);
      relays(2'h0, 2'h0);
      $display("relay test done");
      report_and_stop();
   end
endmodule
